// >>> src/tx_formatter.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps

// What this block does
// - Block request: control, node, offset, length words
// - Sixteen-bit byte count sets payload bytes sent
// - Lock code only for locks, else zero
// - Zero byte count means no payload words
// - First payload byte sits in top byte
// - Zero-pad last quadlet to whole quadlets
// - PHY packet: two raw quadlets, control dropped
// - No CRC appended for PHY packets
// - Source bus select picks 3ff or bus
// - Three-bit speed code travels with packet
// - Transaction label copied unchanged to wire
// - Retry code always set to exclusive scheme
// - Four-bit transaction code selects the format
// - Reserved header bits forwarded untouched
// - Node identifier is bus above node
// - Write response: three words, no payload
// - Quadlet read response: data in word four
// - Wire order: target first, source second
module tx_formatter
    import tx_fmt_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    async_tx_if.formatter    tx,
    input  wire logic [9:0]  local_bus_number,
    input  wire logic [5:0]  local_node_number,
    output logic [31:0]      link_data,
    output logic             link_valid,
    input  wire logic        link_ready,
    output logic             link_first,
    output logic             link_last,
    output logic [2:0]       link_speed,
    output logic             link_no_crc
);
    // ********************
    // Declarations
    // ********************
    typedef enum logic [3:0] {
        S_CTRL    = 4'b0001,
        S_FETCH   = 4'b0010,
        S_EMIT    = 4'b0100,
        S_PAYLOAD = 4'b1000
    } fmt_state_t;

    fmt_state_t  state_reg;
    logic [31:0] hdr_reg [0:3];
    logic [2:0]  idx_reg;
    logic [15:0] rem_reg;
    logic [31:0] fifo_word;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [31:0] out_data_reg;
    logic        out_valid_reg;
    logic        out_first_reg;
    logic        out_last_reg;
    logic [2:0]  out_speed_reg;
    logic        out_no_crc_reg;
    logic        out_free;
    logic [3:0]  transaction_code;
    logic [2:0]  n_in;
    logic [2:0]  n_out;
    logic [15:0] len;
    logic        has_payload;
    logic [15:0] source_id;
    logic        emit_step;
    logic        last_hdr;

    // ********************
    // Transmit FIFO
    // ********************
    sync_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_data   (tx.tx_word),
        .in_valid  (tx.tx_valid),
        .in_ready  (tx.tx_ready),
        .out_data  (fifo_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ********************
    // Decoding of the collected header
    // ********************
    // code picks format
    assign transaction_code       = hdr_reg[0][TRANSACTION_CODE_LSB +: 4];
    assign n_in        = hdr_words(transaction_code);
    assign n_out       = (transaction_code == TC_PHY) ? 3'h2 : n_in;
    assign len         = hdr_reg[3][LEN_LSB +: 16];
    assign has_payload = is_block(transaction_code) && (len != LEN_ZERO);
    assign source_id   = {hdr_reg[0][SRC_SEL_BIT] ? local_bus_number
                                                  : BUS_ALL_ONES,
                          local_node_number};
    assign out_free    = !out_valid_reg || link_ready;
    assign emit_step   = (state_reg == S_EMIT) && out_free;
    assign last_hdr    = (idx_reg == n_out - 3'h1);

    assign fifo_pop = fifo_valid && ((state_reg == S_CTRL)
                    || (state_reg == S_FETCH)
                    || ((state_reg == S_PAYLOAD) && out_free));

    // Wire quadlet for a header slot.
    function automatic logic [31:0] wire_quad(input logic [2:0] i);
        if (transaction_code == TC_PHY) begin
            wire_quad = (i == 3'h0) ? hdr_reg[1] : hdr_reg[2];
        end else begin
            unique case (i)
                3'h0:    wire_quad = {hdr_reg[1][DEST_LSB +: 16],
                                      hdr_reg[0][15:0]};
                3'h1:    wire_quad = {source_id, hdr_reg[1][15:0]};
                3'h2:    wire_quad = hdr_reg[2];
                default: wire_quad = hdr_reg[3];
            endcase
        end
    endfunction

    // Keep only the bytes still owed; the rest become zero padding.
    function automatic logic [31:0] pad_quad(input logic [31:0] w,
                                             input logic [15:0] r);
        unique case (r)
            16'h0001: pad_quad = {w[31:24], 24'h000000};
            16'h0002: pad_quad = {w[31:16], 16'h0000};
            16'h0003: pad_quad = {w[31:8], 8'h00};
            default:  pad_quad = w;
        endcase
    endfunction

    // ********************
    // Sequencing
    // ********************
    // Unknown codes drop just the control word and hunt for the next.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_CTRL;
            idx_reg   <= 3'h0;
        end else begin
            unique case (state_reg)
                S_CTRL: begin
                    if (fifo_valid
                        && hdr_words(fifo_word[TRANSACTION_CODE_LSB +: 4]) != 3'h1) begin
                        state_reg <= S_FETCH;
                        idx_reg   <= 3'h1;
                    end
                end
                S_FETCH: begin
                    if (fifo_valid) begin
                        if (idx_reg == n_in - 3'h1) begin
                            state_reg <= S_EMIT;
                            idx_reg   <= 3'h0;
                        end else begin
                            idx_reg <= idx_reg + 3'h1;
                        end
                    end
                end
                S_EMIT: begin
                    if (out_free) begin
                        idx_reg <= idx_reg + 3'h1;
                        if (last_hdr) begin
                            state_reg <= has_payload ? S_PAYLOAD : S_CTRL;
                        end
                    end
                end
                S_PAYLOAD: begin
                    if (fifo_pop && rem_reg <= QUAD_BYTES) begin
                        state_reg <= S_CTRL;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                hdr_reg[i] <= '0;
            end
        end else if (fifo_pop && state_reg == S_CTRL) begin
            hdr_reg[0] <= fifo_word;
        end else if (fifo_pop && state_reg == S_FETCH) begin
            hdr_reg[idx_reg[1:0]] <= fifo_word;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rem_reg <= '0;
        end else if (emit_step && last_hdr) begin
            rem_reg <= len;
        end else if (fifo_pop && state_reg == S_PAYLOAD) begin
            rem_reg <= (rem_reg > QUAD_BYTES) ? rem_reg - QUAD_BYTES : '0;
        end
    end

    // ********************
    // Link output stage
    // ********************
    // One holding register; it refills on the edge the link takes it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid_reg  <= 1'b0;
            out_data_reg   <= '0;
            out_first_reg  <= 1'b0;
            out_last_reg   <= 1'b0;
            out_speed_reg  <= '0;
            out_no_crc_reg <= 1'b0;
        end else if (emit_step) begin
            out_valid_reg  <= 1'b1;
            out_data_reg   <= wire_quad(idx_reg);
            out_first_reg  <= (idx_reg == 3'h0);
            out_last_reg   <= last_hdr && !has_payload;
            out_speed_reg  <= hdr_reg[0][SPEED_LSB +: 3];
            out_no_crc_reg <= (transaction_code == TC_PHY);
        end else if (fifo_pop && state_reg == S_PAYLOAD) begin
            out_valid_reg  <= 1'b1;
            out_data_reg   <= pad_quad(fifo_word, rem_reg);
            out_first_reg  <= 1'b0;
            out_last_reg   <= (rem_reg <= QUAD_BYTES);
        end else if (link_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    assign link_data   = out_data_reg;
    assign link_valid  = out_valid_reg;
    assign link_first  = out_first_reg;
    assign link_last   = out_last_reg;
    assign link_speed  = out_speed_reg;
    assign link_no_crc = out_no_crc_reg;
endmodule // tx_formatter

// >>> src/tx_fmt_pkg.sv
package tx_fmt_pkg;

    // ********************
    // Internal header quadlet layout
    // ********************
    localparam int SRC_SEL_BIT = 23;
    localparam int SPEED_LSB   = 16;
    localparam int RETRY_LSB   = 8;
    localparam int TRANSACTION_CODE_LSB   = 4;
    localparam int LEN_LSB     = 16;
    localparam int DEST_LSB    = 16;

    localparam logic [9:0] BUS_ALL_ONES  = 10'h3ff;
    localparam logic [1:0] RETRY_EXCL    = 2'h1;
    localparam logic [2:0] SPEED_S400    = 3'h2;
    localparam logic [15:0] QUAD_BYTES   = 16'h0004;
    localparam logic [15:0] LEN_ZERO     = 16'h0000;

    // ********************
    // Transaction codes handled here
    // ********************
    localparam logic [3:0] TC_WR_BLOCK = 4'h1;
    localparam logic [3:0] TC_WR_RESP  = 4'h2;
    localparam logic [3:0] TC_RD_QRESP = 4'h6;
    localparam logic [3:0] TC_LOCK_REQ = 4'h9;
    localparam logic [3:0] TC_PHY      = 4'he;

    // Index that marks payload after the header words.
    localparam logic [2:0] POS_PAYLOAD = 3'h4;

    // Words of internal header, control word included; 1 means unknown.
    function automatic logic [2:0] hdr_words(input logic [3:0] tc);
        unique case (tc)
            TC_WR_BLOCK, TC_LOCK_REQ, TC_RD_QRESP: hdr_words = 3'h4;
            TC_WR_RESP, TC_PHY:                    hdr_words = 3'h3;
            default:                               hdr_words = 3'h1;
        endcase
    endfunction

    // True for the formats that carry a block payload.
    function automatic logic is_block(input logic [3:0] tc);
        is_block = (tc == TC_WR_BLOCK) || (tc == TC_LOCK_REQ);
    endfunction

    // ********************
    // Host register map (APB byte offsets)
    // ********************
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] PUSH_OFS   = 8'h04;
    localparam logic [7:0] COUNT_OFS  = 8'h08;

endpackage

// >>> src/async_tx_if.sv
`timescale 1ns/1ps

// Word channel from the supplier into the formatter's transmit FIFO.
interface async_tx_if;
    logic [31:0] tx_word;
    logic        tx_valid;
    logic        tx_ready;

    modport formatter (input tx_word, input tx_valid, output tx_ready);
    modport supplier  (output tx_word, output tx_valid, input tx_ready);
endinterface

// >>> src/sync_fifo.sv
`timescale 1ns/1ps

module sync_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             do_wr;
    logic             do_rd;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // Storage needs no reset; only the pointers and the occupancy count carry state.
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                                                           : wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                                                           : rd_ptr_reg + 1'b1;
            end
        end
    end

    // Occupancy count.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
        end else if (do_wr && !do_rd) begin
            count_reg <= count_reg + 1'b1;
        end else if (do_rd && !do_wr) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule // sync_fifo

// >>> src/tx_supplier.sv
`timescale 1ns/1ps

module tx_supplier
    import tx_fmt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    async_tx_if.supplier     tx
);
    // ********************
    // Declarations
    // ********************
    logic [31:0] word_reg;
    logic        word_valid_reg;
    logic [2:0]  pos_reg;
    logic [3:0]  transaction_code_reg;
    logic [14:0] left_reg;
    logic [15:0] pkt_count_reg;
    logic [31:0] prdata_reg;
    logic        is_push;
    logic        mapped;
    logic        push;
    logic [31:0] shaped;
    logic [15:0] len;
    logic [2:0]  n_hdr;
    logic        pkt_done;

    // ********************
    // APB decode
    // ********************
    assign is_push = pwrite && (paddr == PUSH_OFS);
    assign mapped  = is_push || (!pwrite && (paddr == STATUS_OFS
                                          || paddr == COUNT_OFS));
    // A push waits while the previous word still sits in the register.
    assign pready  = !(is_push && word_valid_reg);
    assign pslverr = psel && penable && !mapped;
    assign push    = psel && penable && is_push && !word_valid_reg;
    assign len     = pwdata[LEN_LSB +: 16];
    assign n_hdr   = hdr_words(transaction_code_reg);

    // Shape the word by its place in the packet.
    always_comb begin
        shaped = pwdata;
        if (pos_reg == 3'h0) begin
            shaped[RETRY_LSB +: 2] = RETRY_EXCL;
        end else if (pos_reg == 3'h3 && is_block(transaction_code_reg)
                     && transaction_code_reg != TC_LOCK_REQ) begin
            shaped[15:0] = 16'h0000;
        end
    end

    // The packet ends at its last header word or last payload word.
    assign pkt_done = push && ((pos_reg == POS_PAYLOAD
                                && left_reg == 15'h0001)
                    || (pos_reg != 3'h0 && pos_reg != POS_PAYLOAD
                        && pos_reg == n_hdr - 3'h1
                        && !(is_block(transaction_code_reg) && len != LEN_ZERO)));

    // ********************
    // Packet position tracking
    // ********************
    // header then payload
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_reg   <= 3'h0;
            transaction_code_reg <= '0;
            left_reg  <= '0;
        end else if (push) begin
            if (pos_reg == 3'h0) begin
                transaction_code_reg <= pwdata[TRANSACTION_CODE_LSB +: 4];
                if (hdr_words(pwdata[TRANSACTION_CODE_LSB +: 4]) != 3'h1) begin
                    pos_reg <= 3'h1;
                end
            end else if (pos_reg == POS_PAYLOAD) begin
                left_reg <= left_reg - 15'h0001;
                pos_reg  <= (left_reg == 15'h0001) ? 3'h0 : POS_PAYLOAD;
            end else if (pos_reg == n_hdr - 3'h1) begin
                if (is_block(transaction_code_reg) && len != LEN_ZERO) begin
                    left_reg <= 15'((17'(len) + 17'h3) >> 2);
                    pos_reg  <= POS_PAYLOAD;
                end else begin
                    pos_reg <= 3'h0;
                end
            end else begin
                pos_reg <= pos_reg + 3'h1;
            end
        end
    end

    // ********************
    // Word register toward the formatter
    // ********************
    // software packs first byte high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word_reg       <= '0;
            word_valid_reg <= 1'b0;
        end else if (push) begin
            word_reg       <= shaped;
            word_valid_reg <= 1'b1;
        end else if (tx.tx_ready) begin
            word_valid_reg <= 1'b0;
        end
    end

    // Packets handed over, wrapping.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pkt_count_reg <= '0;
        end else if (pkt_done) begin
            pkt_count_reg <= pkt_count_reg + 16'h0001;
        end
    end

    // Read data is latched in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_reg <= '0;
        end else if (psel && !penable) begin
            unique case (paddr)
                STATUS_OFS: prdata_reg <= {28'h0000000, pos_reg,
                                           word_valid_reg};
                COUNT_OFS:  prdata_reg <= {16'h0000, pkt_count_reg};
                default:    prdata_reg <= '0;
            endcase
        end
    end

    assign prdata      = prdata_reg;
    assign tx.tx_word  = word_reg;
    assign tx.tx_valid = word_valid_reg;
endmodule // tx_supplier

// >>> verif/async_tx_monitor.sv
`timescale 1ns/1ps

// ********************************************
// Word channel and link framing checks
// ********************************************
module async_tx_monitor (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [31:0] tx_word,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [31:0] link_data,
    input wire logic        link_valid,
    input wire logic        link_ready,
    input wire logic        link_first,
    input wire logic        link_last,
    input wire logic [2:0]  link_speed,
    input wire logic        link_no_crc
);
    logic [7:0] idx_reg;
    logic       take;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Quadlet position in the packet, so framing can be judged by index.
    assign take = link_valid && link_ready;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            idx_reg <= 8'h00;
        else if (take)
            idx_reg <= link_last ? 8'h00 : idx_reg + 8'h01;
    end

    chk_word_held: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_word)) else $error("word dropped early");
    chk_link_held: assert property (link_valid && !link_ready |=>
        link_valid && $stable(link_data) && $stable(link_last))
        else $error("link quadlet changed while stalled");
    chk_first_index: assert property (link_valid && link_first |->
        idx_reg == 8'h00) else $error("first flag off position");
    chk_first_flag: assert property (link_valid && idx_reg == 8'h00 |->
        link_first) else $error("packet start not flagged");
    chk_phy_two: assert property (link_valid && link_no_crc &&
        idx_reg == 8'h01 |-> link_last) else $error("PHY not two quadlets");
    chk_resp_three: assert property (link_valid && link_last &&
        !link_no_crc |-> idx_reg >= 8'h02) else $error("packet too short");
    chk_speed_held: assert property (link_valid && !link_first |->
        $stable(link_speed)) else $error("speed changed in packet");
    chk_crc_held: assert property (link_valid && !link_first |->
        $stable(link_no_crc)) else $error("no_crc changed in packet");
    chk_last_next: assert property (take && link_last |=>
        !link_valid || link_first) else $error("packet end not followed");

    cover property (take && link_no_crc && link_last);
    cover property (take && link_last && idx_reg >= 8'h05);
    cover property (tx_valid && !tx_ready);
endmodule // async_tx_monitor

// >>> verif/tb.sv
`timescale 1ns/1ps

module tb;
    import tx_fmt_pkg::*;
    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] link_data;
    logic        link_valid;
    logic        link_ready;
    logic        link_first;
    logic        link_last;
    logic [2:0]  link_speed;
    logic        link_no_crc;
    logic [9:0]  bus_num;
    logic [5:0]  node_num;
    logic        stalled;
    logic [31:0] rd;
    logic        err;
    int          miscompares;
    int          n_tests;
    logic [31:0] got_q[$];
    logic [5:0]  flg_q[$];
    logic [31:0] exp_q[$];

    async_tx_if tx_if ();
    tx_supplier tx_supplier_i (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx(tx_if));
    tx_formatter tx_formatter_i (.clk(clk),
        .arst_n(arst_n), .tx(tx_if), .local_bus_number(bus_num),
        .local_node_number(node_num), .link_data(link_data),
        .link_valid(link_valid), .link_ready(link_ready),
        .link_first(link_first), .link_last(link_last),
        .link_speed(link_speed), .link_no_crc(link_no_crc));
    async_tx_monitor async_tx_monitor_i (.clk(clk), .arst_n(arst_n),
        .tx_word(tx_if.tx_word), .tx_valid(tx_if.tx_valid),
        .tx_ready(tx_if.tx_ready), .link_data(link_data),
        .link_valid(link_valid), .link_ready(link_ready),
        .link_first(link_first), .link_last(link_last),
        .link_speed(link_speed), .link_no_crc(link_no_crc));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Collect every quadlet the link takes, with its framing flags.
    always @(posedge clk) begin
        if (link_valid === 1'b1 && link_ready === 1'b1) begin
            got_q.push_back(link_data);
            flg_q.push_back({link_first, link_last, link_no_crc, link_speed});
        end
        if (tx_if.tx_valid === 1'b1 && tx_if.tx_ready === 1'b0)
            stalled = 1'b1;
    end

    task automatic results();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits on pready, never on a fixed count.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 400);
        if (n >= 400) begin
            miscompares++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic push(input logic [31:0] d);
        apb(1'b1, PUSH_OFS, d);
        check({31'h0, err}, 32'h0);
    endtask

    function automatic logic [31:0] mk(input logic sel, input logic [2:0] s,
                                       input logic [1:0] rt,
                                       input logic [3:0] tc);
        mk = {8'h00, sel, 4'h0, s, 6'h2d, rt, tc, 4'ha};
    endfunction

    function automatic logic [15:0] src(input logic sel);
        src = {sel ? bus_num : 10'h3ff, node_num};
    endfunction

    // Wait for the expected packet, then compare data and framing.
    task automatic expect_pkt(input logic nocrc, input logic [2:0] s);
        int n;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) begin
            miscompares++;
            results();
        end
        repeat (6) @(posedge clk);
        check(32'(got_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) begin
            check(got_q[i], exp_q[i]);
            check({26'h0, flg_q[i]}, {26'h0, i == 0,
                  i == exp_q.size() - 1, nocrc, s});
        end
        got_q.delete();
        flg_q.delete();
        exp_q.delete();
    endtask

    // Block write or lock: header reordering, padding, source bus.
    task automatic s_block(input logic [3:0] tc, input logic sel,
                           input logic [2:0] s, input logic [15:0] len);
        logic [31:0] c;
        logic [31:0] w;
        c = mk(sel, s, 2'b00, tc);
        push(c);
        push(32'h1234_5678);
        push(32'h9abc_def0);
        push({len, 16'h00c3});
        exp_q.push_back({16'h1234, c[15:10], 2'b01, c[7:0]});
        exp_q.push_back({src(sel), 16'h5678});
        exp_q.push_back(32'h9abc_def0);
        exp_q.push_back({len, tc == TC_LOCK_REQ ? 16'h00c3 : 16'h0});
        for (int i = 0; i < (len + 3) / 4; i++) begin
            w = 32'h1122_3344 + i * 32'h0101_0101;
            push(w);
            if (i == (len + 3) / 4 - 1 && len[1:0] != 2'b00)
                w = w & ~(32'hffff_ffff >> (8 * len[1:0]));
            exp_q.push_back(w);
        end
        expect_pkt(1'b0, s);
    endtask

    // Write response or quadlet read response.
    task automatic s_short(input logic [3:0] tc, input logic [2:0] s);
        logic [31:0] c;
        c = mk(1'b0, s, 2'b01, tc);
        push(c);
        push(32'hfedc_0000);
        push(32'h5000_0000);
        exp_q.push_back({16'hfedc, c[15:0]});
        exp_q.push_back({src(1'b0), 16'h0000});
        exp_q.push_back(32'h5000_0000);
        if (tc == TC_RD_QRESP) begin
            push(32'hcafe_f00d);
            exp_q.push_back(32'hcafe_f00d);
        end
        expect_pkt(1'b0, s);
    endtask

    // Unknown code dropped, then a raw two-quadlet PHY packet.
    task automatic s_phy();
        push(mk(1'b0, 3'h0, 2'b01, 4'h3));
        push(mk(1'b1, 3'h2, 2'b01, TC_PHY));
        push(32'h00ff_a5a5);
        push(32'hff00_5a5a);
        exp_q.push_back(32'h00ff_a5a5);
        exp_q.push_back(32'hff00_5a5a);
        expect_pkt(1'b1, 3'h2);
    endtask

    // Link stalls while a long block fills the FIFO until it refuses.
    task automatic s_stall();
        stalled = 1'b0;
        link_ready <= 1'b0;
        fork
            begin
                repeat (150) @(posedge clk);
                link_ready <= 1'b1;
            end
        join_none
        s_block(TC_WR_BLOCK, 1'b1, 3'h0, 16'd69);
        check({31'h0, stalled}, 32'h1);
    endtask

    task automatic s_regs();
        apb(1'b0, PUSH_OFS, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, STATUS_OFS, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, COUNT_OFS, 32'h0);
        check({16'h0, rd[15:0]}, 32'd7);
    endtask

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        link_ready = 1'b1;
        bus_num = 10'h155;
        node_num = 6'h2a;
        miscompares = 0;
        n_tests = 0;
        stalled = 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        s_block(TC_WR_BLOCK, 1'b1, 3'h2, 16'd5);
        s_block(TC_LOCK_REQ, 1'b0, 3'h1, 16'd0);
        s_block(TC_LOCK_REQ, 1'b1, 3'h0, 16'd8);
        s_short(TC_WR_RESP, 3'h0);
        s_short(TC_RD_QRESP, 3'h1);
        s_phy();
        bus_num <= 10'h2c3;
        node_num <= 6'h15;
        s_stall();
        s_regs();
        results();
    end
endmodule // tb
